/* hdl/udm_link_if.sv */
// udm_link_if: wires between the monitor and the user logic in the core
// assumes both ends run on the same clock; no tristate pins
`timescale 1ns/10ps
interface udm_link_if;
  logic start;
  logic inject_error;
  logic error_clear;
  logic reconfig_req;
  logic error;
  logic done;

  modport monitor
  (
    input  start,
    input  inject_error,
    input  error_clear,
    input  reconfig_req,
    output error,
    output done
  );

  modport user
  (
    output start,
    output inject_error,
    output error_clear,
    output reconfig_req,
    input  error,
    input  done
  );
endinterface

/* hdl/udm_monitor.sv */
// udm_monitor: configuration memory upset monitor, device end
// assumes configuration_memory is read one word per cycle through a read port,
// and that user inputs on the link may be asynchronous to CLOCK
`timescale 1ns/10ps
module udm_monitor
  import udm_pkg::*;
#(
  parameter int unsigned ADDR_W      = 10,
  parameter int unsigned MEM_WORDS   = 1024,
  parameter int unsigned INTERVAL_US = INTERVAL_DEF_US,
  parameter int unsigned CYCLES_US   = CYCLES_PER_US
)
(
  input  wire logic                CLOCK,
  input  wire logic                NRST,
  udm_link_if.monitor              LINK,
  input  wire logic                AUTO_MODE,
  input  wire udm_cfg_mode_e       CFG_MODE,
  input  wire logic [CRC_W-1:0]    REF_CRC,
  output logic      [ADDR_W-1:0]   MEM_ADDR,
  input  wire logic [CRC_W-1:0]    MEM_DATA,
  output logic                     RECONFIG
);

  localparam int unsigned TICKS = INTERVAL_US * CYCLES_US;
  localparam int unsigned CNT_W = $clog2(TICKS + 1);
  localparam logic [ADDR_W-1:0] LAST_ADDR = ADDR_W'(MEM_WORDS - 1);

  // ---------------------------------------------------------------
  // crc step over one 32-bit word, msb first
  // ---------------------------------------------------------------
  function automatic logic [CRC_W-1:0] crc_word(input logic [CRC_W-1:0] c,
                                                input logic [CRC_W-1:0] d);
    logic [CRC_W-1:0] r;
    r = c;
    for (int i = CRC_W - 1; i >= 0; i--)
    begin
      r = (r[CRC_W-1] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // input synchronisers and rising-edge detect
  // ---------------------------------------------------------------
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] seen;
  logic [3:0] rise;
  logic [3:0] raw;

  assign raw = {LINK.reconfig_req, LINK.error_clear, LINK.inject_error, LINK.start};

  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      seen  <= 4'h0;
    end
    else
    begin
      sync1 <= raw;
      sync2 <= sync1;
      seen  <= sync2;
    end
  end

  // an edge, not a level, so a long pulse is taken only once
  assign rise = sync2 & ~seen;

  wire start_p  = rise[0];
  wire inject_p = rise[1];
  wire clear_p  = rise[2];
  wire recfg_p  = rise[3];

  // ---------------------------------------------------------------
  // check trigger
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] tick;
  udm_state_e       state;
  logic             trigger;

  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      tick <= '0;
    end
    else if (!AUTO_MODE || clear_p || state != UDM_IDLE)
    begin
      tick <= '0;
    end
    else if (tick == CNT_W'(TICKS - 1))
    begin
      tick <= '0;
    end
    else
    begin
      tick <= tick + CNT_W'(1);
    end
  end

  always_comb
  begin
    if (AUTO_MODE)
    begin
      trigger = (tick == CNT_W'(TICKS - 1));
    end
    else
    begin
      trigger = start_p;
    end
  end

  // ---------------------------------------------------------------
  // scan state machine: reads memory through its own port, so user
  // logic keeps running throughout
  // ---------------------------------------------------------------
  logic [CRC_W-1:0] crc;
  logic             error;
  logic             done;
  logic             mismatch;

  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      state    <= UDM_IDLE;
      MEM_ADDR <= '0;
      crc      <= CRC_INIT;
    end
    else if (clear_p)
    begin
      state    <= UDM_IDLE;
      MEM_ADDR <= '0;
      crc      <= CRC_INIT;
    end
    else
    begin
      unique case (state)
        UDM_IDLE:
        begin
          if (trigger)
          begin
            state    <= UDM_SCAN;
            MEM_ADDR <= '0;
            crc      <= CRC_INIT;
          end
        end
        UDM_SCAN:
        begin
          crc <= crc_word(crc, MEM_DATA);
          if (MEM_ADDR == LAST_ADDR)
          begin
            state <= UDM_CHECK;
          end
          else
          begin
            MEM_ADDR <= MEM_ADDR + ADDR_W'(1);
          end
        end
        UDM_CHECK:
        begin
          state <= mismatch ? UDM_HOLD : UDM_IDLE;
        end
        UDM_HOLD:
        begin
          state <= UDM_HOLD;
        end
      endcase
    end
  end

  assign mismatch = (crc != REF_CRC);

  // ---------------------------------------------------------------
  // status flags: a new event in the clear cycle wins
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      error <= 1'b0;
    end
    else if (inject_p || (state == UDM_CHECK && mismatch))
    begin
      error <= 1'b1;
    end
    else if (clear_p)
    begin
      error <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      done <= 1'b0;
    end
    else if (state == UDM_CHECK)
    begin
      done <= 1'b1;
    end
    else if (clear_p || (state == UDM_IDLE && trigger))
    begin
      done <= 1'b0;
    end
  end

  assign LINK.error = error;
  assign LINK.done  = done;

  // ---------------------------------------------------------------
  // reconfiguration request: only on user demand, only in active mode
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      RECONFIG <= 1'b0;
    end
    else
    begin
      RECONFIG <= recfg_p && (CFG_MODE == UDM_CFG_ACTIVE);
    end
  end

endmodule

/* hdl/udm_pkg.sv */
// udm_pkg: shared constants for the upset detection monitor and its user-side driver
// assumes a single 200 MHz clock shared by both ends
package udm_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS    = 5000;
  localparam int unsigned PULSE_MIN_NS     = 500;
  localparam int unsigned PULSE_MIN_CYCLES = (PULSE_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
                                             / CLK_PERIOD_PS;
  localparam int unsigned INTERVAL_MIN_US  = 1;
  localparam int unsigned INTERVAL_DEF_US  = 1650000;
  localparam int unsigned CYCLES_PER_US    = 1000000 / CLK_PERIOD_PS;

  // ---------------------------------------------------------------
  // crc
  // ---------------------------------------------------------------
  localparam int unsigned CRC_W    = 32;
  localparam logic [31:0] CRC_POLY = 32'h04c11db7;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;

  // ---------------------------------------------------------------
  // configuration modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0]
  {
    UDM_CFG_ACTIVE  = 2'h0,
    UDM_CFG_PASSIVE = 2'h1,
    UDM_CFG_JTAG    = 2'h3
  } udm_cfg_mode_e;

  // ---------------------------------------------------------------
  // monitor states
  // ---------------------------------------------------------------
  typedef enum logic [1:0]
  {
    UDM_IDLE  = 2'b00,
    UDM_SCAN  = 2'b01,
    UDM_CHECK = 2'b11,
    UDM_HOLD  = 2'b10
  } udm_state_e;

endpackage

/* hdl/udm_user.sv */
// udm_user: user-logic end that drives the monitor's pulse inputs
// assumes one request pulse per command; the monitor sits on the same clock
`timescale 1ns/10ps
module udm_user
  import udm_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = PULSE_MIN_CYCLES
)
(
  input  wire logic       CLOCK,
  input  wire logic       NRST,
  udm_link_if.user        LINK,
  input  wire logic [3:0] REQ,
  input  wire logic       IDLE_OK,
  output logic            BUSY,
  output logic            ERROR,
  output logic            DONE
);

  localparam int unsigned CNT_W = $clog2(PULSE_CYCLES + 1);

  // ---------------------------------------------------------------
  // one stretcher per line: start, inject, clear, reconfig
  // ---------------------------------------------------------------
  logic [3:0] line;
  logic [3:0] busy_v;

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : gen_line
      logic [CNT_W-1:0] cnt;
      logic             pulse;
      // a start is dropped, not held, unless the design is idle on small parts
      wire go = REQ[g] && (cnt == '0) && (g != 0 || IDLE_OK);

      always_ff @(posedge CLOCK or negedge NRST)
      begin
        if (!NRST)
        begin
          cnt <= '0;
        end
        else if (go)
        begin
          cnt <= CNT_W'(PULSE_CYCLES);
        end
        else if (cnt != '0)
        begin
          cnt <= cnt - CNT_W'(1);
        end
      end

      // each lane owns its flop, so no two processes write into one vector
      always_ff @(posedge CLOCK or negedge NRST)
      begin
        if (!NRST)
        begin
          pulse <= 1'b0;
        end
        else
        begin
          pulse <= go || (cnt > CNT_W'(1));
        end
      end

      assign line[g]   = pulse;
      assign busy_v[g] = (cnt != '0);
    end
  endgenerate

  assign LINK.start        = line[0];
  assign LINK.inject_error = line[1];
  assign LINK.error_clear  = line[2];
  assign LINK.reconfig_req = line[3];
  assign BUSY              = |busy_v;

  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      ERROR <= 1'b0;
      DONE  <= 1'b0;
    end
    else
    begin
      ERROR <= LINK.error;
      DONE  <= LINK.done;
    end
  end

endmodule

/* verif/udm_link_chk.sv */
// udm_link_chk: timing relations on the monitor to user link
// assumes it is instantiated beside the link interface, one clock domain
`timescale 1ns/10ps
module udm_link_chk
(
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic AUTO_MODE,
  input wire logic start,
  input wire logic inject_error,
  input wire logic error_clear,
  input wire logic error,
  input wire logic done
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  // ---------------------------------------------------------------
  // error flag
  // ---------------------------------------------------------------
  property p_inj_set; $rose(inject_error) |-> ##[2:6] error; endproperty
  a_inj_set: assert property (p_inj_set)
    else $error("inject pulse did not raise error");
  // two sync flops sit in front, so no reaction on the next edge
  property p_inj_sync; $rose(inject_error) && !error |=> !error; endproperty
  a_inj_sync: assert property (p_inj_sync)
    else $error("inject acted without synchronisation");
  property p_err_sticky; $fell(error) |-> error_clear; endproperty
  a_err_sticky: assert property (p_err_sticky)
    else $error("error fell without clear");
  property p_clr_drop; $rose(error_clear) |-> ##[2:6] (!error && !done); endproperty
  a_clr_drop: assert property (p_clr_drop)
    else $error("clear did not drop error and done");
  property p_clr_once; error_clear && !error && !inject_error |=> !error; endproperty
  a_clr_once: assert property (p_clr_once)
    else $error("error rose while clear held");
  // ---------------------------------------------------------------
  // completion flag
  // ---------------------------------------------------------------
  property p_done_hold; $fell(done) && $past(error) |-> error_clear; endproperty
  a_done_hold: assert property (p_done_hold)
    else $error("done fell after upset without clear");
  property p_start_done;
    $rose(start) && !AUTO_MODE && !error |-> ##[3:40] $rose(done);
  endproperty
  a_start_done: assert property (p_start_done)
    else $error("manual start gave no done");
  property p_err_done; $rose(error) && !inject_error |-> $rose(done); endproperty
  a_err_done: assert property (p_err_done)
    else $error("mismatch error without done");
endmodule

/* verif/upset_detection_monitor_test.sv */
// upset_detection_monitor_test: both ends joined by the link, user side driven
// assumes an 8 word memory model and a 1 us auto interval to keep runs short
`timescale 1ns/10ps
module upset_detection_monitor_test
  import udm_pkg::*;
;
  logic          CLOCK = 0;
  logic          NRST = 0;
  logic          AUTO_MODE = 0;
  logic          IDLE_OK = 1;
  udm_cfg_mode_e CFG_MODE = UDM_CFG_ACTIVE;
  logic [31:0]   REF_CRC = 32'h0;
  logic [3:0]    REQ = 4'h0;
  logic [2:0]    MEM_ADDR;
  logic [31:0]   MEM_DATA;
  logic          RECONFIG, BUSY, ERROR, DONE, dq;
  int            n_fail = 0, n_tests = 0, n_rcf = 0, n_done = 0, wid = 0;
  udm_cfg_mode_e modes [3] = '{UDM_CFG_ACTIVE, UDM_CFG_PASSIVE, UDM_CFG_JTAG};
  udm_link_if link();
  always #2.5 CLOCK = ~CLOCK;
  function automatic logic [31:0] word(input logic [2:0] a);
    return {a, 29'h0a5c3e1} ^ 32'h9e3779b9;
  endfunction
  assign MEM_DATA = word(MEM_ADDR);
  function automatic logic [31:0] crc_all();
    logic [31:0] c;
    logic [31:0] w;
    c = CRC_INIT;
    for (int i = 0; i < 8; i++)
    begin
      w = word(i[2:0]);
      for (int b = 31; b >= 0; b--)
        c = {c[30:0], 1'b0} ^ ((c[31] ^ w[b]) ? CRC_POLY : 32'h0);
    end
    return c;
  endfunction
  udm_monitor #(.ADDR_W(3), .MEM_WORDS(8), .INTERVAL_US(1)) i_udm_monitor
    (.CLOCK(CLOCK), .NRST(NRST), .LINK(link), .AUTO_MODE(AUTO_MODE), .CFG_MODE(CFG_MODE),
     .REF_CRC(REF_CRC), .MEM_ADDR(MEM_ADDR), .MEM_DATA(MEM_DATA), .RECONFIG(RECONFIG));
  udm_user i_udm_user (.CLOCK(CLOCK), .NRST(NRST), .LINK(link), .REQ(REQ),
    .IDLE_OK(IDLE_OK), .BUSY(BUSY), .ERROR(ERROR), .DONE(DONE));
  udm_link_chk i_udm_link_chk (.CLOCK(CLOCK), .NRST(NRST), .AUTO_MODE(AUTO_MODE),
    .start(link.start), .inject_error(link.inject_error), .error_clear(link.error_clear),
    .error(link.error), .done(link.done));
  always @(posedge CLOCK)
  begin
    if (RECONFIG === 1'b1) n_rcf++;
    if (link.start === 1'b1) wid++;
    if (DONE === 1'b1 && dq !== 1'b1) n_done++;
    dq = DONE;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask
  // one cycle request, then wait for the stretcher and the monitor's reaction
  task automatic req(input int b);
    REQ[b] = 1'b1;
    cyc(1);
    REQ[b] = 1'b0;
    for (int i = 0; i < 300 && BUSY !== 1'b0; i++) cyc(1);
    cyc(8);
  endtask
  task automatic t_reset();
    repeat (6) @(posedge CLOCK);
    #1 NRST = 1'b1;
    cyc(2);
    chk("reset error", ERROR, 0);
    chk("reset done", DONE, 0);
    chk("reset busy", BUSY, 0);
    $display("t_reset ends");
  endtask
  // start dropped while the design is not idle, no pulse reaches the monitor
  task automatic t_idle();
    IDLE_OK = 1'b0;
    wid = 0;
    req(0);
    chk("gated start", wid, 0);
    chk("gated busy", BUSY, 0);
    chk("gated done", DONE, 0);
    IDLE_OK = 1'b1;
    $display("t_idle ends");
  endtask
  task automatic t_check(input logic bad);
    REF_CRC = crc_all() ^ {31'h0, bad};
    wid = 0;
    req(0);
    chk("start width", wid >= PULSE_MIN_CYCLES, 1);
    chk("done", DONE, 1);
    chk("error", ERROR, bad);
    cyc(300);
    chk("done held", DONE, 1);
    chk("error held", ERROR, bad);
    chk("no reconfig", n_rcf, 0);
    $display("t_check ends");
  endtask
  task automatic t_clear();
    req(2);
    chk("error cleared", ERROR, 0);
    chk("done cleared", DONE, 0);
    $display("t_clear ends");
  endtask
  task automatic t_inject();
    req(1);
    cyc(200);
    chk("injected error", ERROR, 1);
    $display("t_inject ends");
  endtask
  task automatic t_reconfig();
    foreach (modes[m])
    begin
      CFG_MODE = modes[m];
      n_rcf = 0;
      req(3);
      chk("reconfig pulses", n_rcf, m == 0);
    end
    $display("t_reconfig ends");
  endtask
  // interval 200 idle cycles plus a short scan: five checks in 1100 cycles
  task automatic t_auto();
    REF_CRC = crc_all();
    AUTO_MODE = 1'b1;
    n_done = 0;
    cyc(1100);
    chk("auto checks", n_done >= 4 && n_done <= 6, 1);
    chk("auto error", ERROR, 0);
    $display("t_auto ends");
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_fail++;
    stop_test();
  end
  initial
  begin
    t_reset();
    t_check(1'b0);
    t_check(1'b1);
    t_clear();
    t_inject();
    t_clear();
    t_idle();
    t_reconfig();
    t_auto();
    stop_test();
  end
endmodule
